// file: rtl/sowr_pkg.sv
// ----------------------------------------------------------------
// sowr_pkg: constants and types of the system options register
// ----------------------------------------------------------------
// holds offsets, reset values, field codes and event positions;
// assumes an apb bus with 16-bit byte addresses and 32-bit data.
package sowr_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [15:0] ADDR_OPTIONS = 16'h1804;
  localparam logic [15:0] ADDR_STATUS = 16'h1808;
  localparam logic [15:0] ADDR_MASK = 16'h180c;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] OPTIONS_RESET = 8'hc0;
  localparam logic [2:0] STATUS_RESET = 3'h0;
  localparam logic [2:0] MASK_RESET = 3'h0;

  // ----------------------------------------------------------------
  // field codes
  // ----------------------------------------------------------------
  localparam logic [1:0] TIMEOUT_OFF = 2'h0;
  localparam logic [1:0] TIMEOUT_SHORT = 2'h1;
  localparam logic [1:0] TIMEOUT_MID = 2'h2;
  localparam logic [1:0] TIMEOUT_LONG = 2'h3;
  localparam logic [1:0] CLK_LOW_POWER_OSC = 2'h0;
  localparam logic [1:0] CLK_SYSTEM_BUS = 2'h1;
  localparam logic [1:0] CLK_INTERNAL_REF = 2'h2;
  localparam logic [1:0] CLK_EXT_PIN = 2'h3;

  // period exponents: slow clocks, then bus or pin clocks
  localparam logic [4:0] EXP_SLOW_SHORT = 5'h05;
  localparam logic [4:0] EXP_SLOW_MID = 5'h08;
  localparam logic [4:0] EXP_SLOW_LONG = 5'h0a;
  localparam logic [4:0] EXP_FAST_SHORT = 5'h0d;
  localparam logic [4:0] EXP_FAST_MID = 5'h10;
  localparam logic [4:0] EXP_FAST_LONG = 5'h12;

  // ----------------------------------------------------------------
  // status layout
  // ----------------------------------------------------------------
  localparam int EV_LATE_WRITE = 0;
  localparam int EV_WINDOW = 1;
  localparam int EV_ILLEGAL_STOP = 2;
  localparam int EV_COUNT = 3;
  localparam int STATUS_LOCK_BIT = 8;

  // options register layout, msb first
  typedef struct packed {
    logic [1:0] watchdog_timeout_select;
    logic [1:0] watchdog_clock_select;
    logic watchdog_window_enable;
    logic ref_range_high;
    logic fast_wakeup_enable;
    logic stop_mode_enable;
  } sowr_opts_t;

endpackage

// file: rtl/sowr_options_reg.sv
// ----------------------------------------------------------------
// sowr_options_reg: write-once system options register on apb
// ----------------------------------------------------------------
// assumes one clock, synchronous active-high reset, and that the
// watchdog counter, service strobe and cpu stop/wake events are
// synchronous to clock_i.
//
// How it works
// - timeout field write-once, selects period
// - timeout code maps to period exponent
// - clock select picks slow or fast table
// - window bit selects normal or window
// - early service write resets the controller
// - range bit drives reference divider range
// - fast wakeup skips interrupt routine
// - stop while disabled gives illegal reset
`timescale 1ns/1ps

module sowr_options_reg #(
  parameter int COUNT_W = 20
) (
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [15:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  output sowr_pkg::sowr_opts_t options_o,
  output logic watchdog_enable_o,
  output logic [4:0] watchdog_period_log2_o,
  input wire logic [COUNT_W-1:0] watchdog_count_i,
  input wire logic service_write_i,
  output logic window_reset_o,
  input wire logic stop_instr_i,
  output logic stop_entry_o,
  output logic illegal_opcode_reset_o,
  input wire logic wakeup_i,
  output logic wake_skip_isr_o,
  output logic ref_range_high_o,
  output logic irq_o
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  sowr_pkg::sowr_opts_t opt_q;
  logic lock_q;
  logic ready_q;
  logic err_q;
  logic [31:0] rdata_q;
  logic [2:0] status_q;
  logic [2:0] status_d;
  logic [2:0] mask_q;
  logic window_q;
  logic stop_q;
  logic illegal_q;
  logic wake_q;

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  // one wait state so read data comes from a flop
  wire access = psel_i & penable_i;
  wire commit = access & ready_q;
  wire wr_commit = commit & pwrite_i & pstrb_i[0];
  wire sel_opt = (paddr_i == sowr_pkg::ADDR_OPTIONS);
  wire sel_status = (paddr_i == sowr_pkg::ADDR_STATUS);
  wire sel_mask = (paddr_i == sowr_pkg::ADDR_MASK);
  wire mapped = sel_opt | sel_status | sel_mask;
  wire wr_opt = wr_commit & sel_opt;
  wire [31:0] read_mux = sel_opt ? {24'h000000, opt_q} :
                         sel_status ? {23'h000000, lock_q, 5'h00, status_q} :
                         sel_mask ? {29'h00000000, mask_q} : 32'h00000000;

  // pready rises on the second access cycle, then drops
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      ready_q <= 1'b0;
      err_q <= 1'b0;
      rdata_q <= 32'h00000000;
    end else begin
      ready_q <= access & ~ready_q;
      err_q <= access & ~ready_q & ~mapped;
      rdata_q <= (access & ~ready_q & ~pwrite_i) ? read_mux : 32'h00000000;
    end
  end

  assign pready_o = ready_q;
  assign pslverr_o = err_q;
  assign prdata_o = rdata_q;

  // ----------------------------------------------------------------
  // write-once options
  // ----------------------------------------------------------------
  // first write locks
  // a later write is dropped but flagged, so software can see
  // that its configuration attempt never landed
  wire late_write = wr_opt & lock_q;

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      opt_q <= sowr_pkg::OPTIONS_RESET;
      lock_q <= 1'b0;
    end else if (wr_opt && !lock_q) begin
      opt_q <= pwdata_i[7:0];
      lock_q <= 1'b1;
    end
  end

  assign options_o = opt_q;

  assign ref_range_high_o = opt_q.ref_range_high;

  // ----------------------------------------------------------------
  // watchdog period
  // ----------------------------------------------------------------
  // clock source table
  wire slow_clk = (opt_q.watchdog_clock_select == sowr_pkg::CLK_LOW_POWER_OSC) |
                  (opt_q.watchdog_clock_select == sowr_pkg::CLK_INTERNAL_REF);
  logic [4:0] exp_sel;

  always_comb begin
    case (opt_q.watchdog_timeout_select)
      sowr_pkg::TIMEOUT_SHORT: begin
        exp_sel = slow_clk ? sowr_pkg::EXP_SLOW_SHORT : sowr_pkg::EXP_FAST_SHORT;
      end
      sowr_pkg::TIMEOUT_MID: begin
        exp_sel = slow_clk ? sowr_pkg::EXP_SLOW_MID : sowr_pkg::EXP_FAST_MID;
      end
      sowr_pkg::TIMEOUT_LONG: begin
        exp_sel = slow_clk ? sowr_pkg::EXP_SLOW_LONG : sowr_pkg::EXP_FAST_LONG;
      end
      default: begin
        exp_sel = 5'h00;
      end
    endcase
  end

  assign watchdog_enable_o = (opt_q.watchdog_timeout_select != sowr_pkg::TIMEOUT_OFF);
  assign watchdog_period_log2_o = exp_sel;

  // ----------------------------------------------------------------
  // window check
  // ----------------------------------------------------------------
  // closed part is the first three quarters of the period;
  // COUNT_W must hold 2^18 or the long periods wrap
  wire [COUNT_W-1:0] period = COUNT_W'(1) << exp_sel;
  wire [COUNT_W-1:0] open_at = period - (period >> 2);
  wire early = watchdog_count_i < open_at;

  wire window_hit = service_write_i & opt_q.watchdog_window_enable &
                    watchdog_enable_o & early;

  // ----------------------------------------------------------------
  // cpu stop and wakeup
  // ----------------------------------------------------------------
  // stop gate
  wire stop_blocked = stop_instr_i & ~opt_q.stop_mode_enable;
  wire stop_allowed = stop_instr_i & opt_q.stop_mode_enable;

  // reset and control pulses, registered one cycle after their inputs
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      window_q <= 1'b0;
      stop_q <= 1'b0;
      illegal_q <= 1'b0;
      wake_q <= 1'b0;
    end else begin
      window_q <= window_hit;
      stop_q <= stop_allowed;
      illegal_q <= stop_blocked;
      wake_q <= wakeup_i & opt_q.fast_wakeup_enable;
    end
  end

  assign window_reset_o = window_q;
  assign stop_entry_o = stop_q;
  assign illegal_opcode_reset_o = illegal_q;
  // the cpu must keep interrupts clear just after stop
  assign wake_skip_isr_o = wake_q;

  // ----------------------------------------------------------------
  // status, mask and interrupt
  // ----------------------------------------------------------------
  // set wins over write-one-to-clear in the same cycle
  wire [2:0] events = {stop_blocked, window_hit, late_write};
  wire [2:0] clr = (wr_commit & sel_status) ? pwdata_i[2:0] : 3'h0;
  assign status_d = (status_q & ~clr) | events;

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      status_q <= sowr_pkg::STATUS_RESET;
      mask_q <= sowr_pkg::MASK_RESET;
    end else begin
      status_q <= status_d;
      if (wr_commit && sel_mask) begin
        mask_q <= pwdata_i[2:0];
      end
    end
  end

  assign irq_o = |(status_q & mask_q);

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (reset_i);

  sequence s_first_write;
    wr_opt && !lock_q;
  endsequence

  sequence s_stop_blocked;
    stop_instr_i && !opt_q.stop_mode_enable;
  endsequence

  sequence s_early_service;
    service_write_i && opt_q.watchdog_window_enable &&
    watchdog_enable_o && (watchdog_count_i < open_at);
  endsequence

  chk_first_write_lands: assert property (
    s_first_write |=> (opt_q == $past(pwdata_i[7:0])) && lock_q)
    else $error("first options write not stored");

  chk_locked_stable: assert property (
    lock_q |=> $stable(opt_q) ##1 $stable(opt_q))
    else $error("locked options changed");

  chk_timeout_map: assert property (
    (opt_q.watchdog_timeout_select == sowr_pkg::TIMEOUT_MID) && slow_clk
    |-> watchdog_period_log2_o == 5'h08)
    else $error("timeout exponent wrong");

  chk_clock_table: assert property (
    (opt_q.watchdog_timeout_select == sowr_pkg::TIMEOUT_LONG) &&
    (opt_q.watchdog_clock_select == sowr_pkg::CLK_EXT_PIN)
    |-> watchdog_period_log2_o == 5'h12 && watchdog_enable_o)
    else $error("clock source table wrong");

  chk_normal_no_reset: assert property (
    !opt_q.watchdog_window_enable && $stable(opt_q) |=> !window_reset_o)
    else $error("window reset in normal mode");

  chk_early_service: assert property (
    s_early_service |=> window_reset_o ##1 (!window_reset_o || $past(window_hit)))
    else $error("early service did not reset");

  chk_range_out: assert property (
    wr_opt && !lock_q |=> ref_range_high_o == $past(pwdata_i[2]))
    else $error("range output not following field");

  chk_fast_wake: assert property (
    wakeup_i |=> wake_skip_isr_o == $past(opt_q.fast_wakeup_enable))
    else $error("fast wakeup skip wrong");

  chk_illegal_stop: assert property (
    s_stop_blocked |=> illegal_opcode_reset_o && !stop_entry_o)
    else $error("blocked stop did not reset");

  chk_status_sticky: assert property (
    status_q[sowr_pkg::EV_ILLEGAL_STOP] && !(wr_commit && sel_status)
    |=> status_q[sowr_pkg::EV_ILLEGAL_STOP])
    else $error("status bit lost");

  // apb answer after exactly one wait state
  chk_ready_timing: assert property (
    psel_i && penable_i && !pready_o |=> pready_o)
    else $error("pready not after one wait state");

  chk_unmapped_err: assert property (
    psel_i && penable_i && !pready_o && !mapped |=> pslverr_o && pready_o)
    else $error("unmapped access not refused");

  chk_late_flag: assert property (
    wr_opt && lock_q |=> status_q[sowr_pkg::EV_LATE_WRITE] && $stable(opt_q))
    else $error("late options write not flagged");

  chk_window_status: assert property (
    window_reset_o |-> status_q[sowr_pkg::EV_WINDOW])
    else $error("window violation not recorded");

  chk_stop_allowed: assert property (
    stop_instr_i && opt_q.stop_mode_enable |=> stop_entry_o && !illegal_opcode_reset_o)
    else $error("enabled stop not passed on");

  chk_watchdog_off: assert property (
    !watchdog_enable_o |-> watchdog_period_log2_o == 5'h00)
    else $error("disabled watchdog has a period");

endmodule

// file: test/system_options_write_once_reg_bench.sv
// sowr bench: apb register tests of the write-once options block
// assumes sowr_pkg and sowr_options_reg compiled first
`timescale 1ns/1ps

module system_options_write_once_reg_bench;
  logic clock_i = 1'b0;
  logic reset_i = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hf;
  logic [19:0] wd_count = 20'h0;
  logic service_write = 1'b0;
  logic stop_instr = 1'b0;
  logic wakeup = 1'b0;
  logic [31:0] prdata_o;
  logic pready_o;
  logic pslverr_o;
  sowr_pkg::sowr_opts_t options_o;
  logic wd_en_o;
  logic [4:0] period_o;
  logic win_rst_o;
  logic stop_entry_o;
  logic illegal_o;
  logic skip_isr_o;
  logic range_o;
  logic irq_o;
  int err_total = 0;
  int comparisons = 0;
  logic [31:0] rd;
  logic er;
  logic [7:0] tbl_val [4] = '{8'h01, 8'h61, 8'hb1, 8'hd1};
  logic [4:0] tbl_per [4] = '{5'h00, 5'h05, 5'h10, 5'h12};

  // 200 mhz clock
  always #2.5 clock_i = ~clock_i;

  sowr_options_reg #(.COUNT_W(20)) i_dut (
    .clock_i(clock_i), .reset_i(reset_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(pstrb),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .options_o(options_o), .watchdog_enable_o(wd_en_o),
    .watchdog_period_log2_o(period_o), .watchdog_count_i(wd_count),
    .service_write_i(service_write), .window_reset_o(win_rst_o),
    .stop_instr_i(stop_instr), .stop_entry_o(stop_entry_o),
    .illegal_opcode_reset_o(illegal_o), .wakeup_i(wakeup),
    .wake_skip_isr_o(skip_isr_o), .ref_range_high_o(range_o), .irq_o(irq_o)
  );

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      $display("FAIL %s expected %h seen %h", name, exp, got);
      err_total++;
    end
  endtask

  // holds the request until pready is sampled high at an edge;
  // only the watchdog ends a wait that never gets an answer
  task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d);
    @(posedge clock_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock_i);
    penable <= 1'b1;
    do begin
      @(posedge clock_i);
    end while (pready_o !== 1'b1);
    rd = prdata_o;
    er = pslverr_o;
    psel <= 1'b0;
    penable <= 1'b0;
    // outputs looked at mid-cycle, once the committing edge settled
    @(negedge clock_i);
  endtask

  task automatic rdchk(input string name, input logic [15:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(name, exp, rd);
  endtask

  // one-cycle event; outputs looked at one edge later
  task automatic pulse(input int k);
    @(posedge clock_i);
    if (k == 0) stop_instr <= 1'b1;
    else if (k == 1) service_write <= 1'b1;
    else wakeup <= 1'b1;
    @(posedge clock_i);
    stop_instr <= 1'b0;
    service_write <= 1'b0;
    wakeup <= 1'b0;
    @(negedge clock_i);
  endtask

  task automatic do_reset(input int n);
    @(posedge clock_i);
    reset_i <= 1'b1;
    repeat (n) @(posedge clock_i);
    reset_i <= 1'b0;
    @(negedge clock_i);
  endtask

  task automatic results();
    $display("comparisons %0d errors %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    do_reset(16);
    rdchk("options", sowr_pkg::ADDR_OPTIONS, 32'h0000_00c0);
    rdchk("status", sowr_pkg::ADDR_STATUS, 32'h0);
    chk("period", 32'h0000000a, {27'h0, period_o});
    pulse(0);
    chk("illegal", 32'h1, {31'h0, illegal_o});
    chk("stop", 32'h0, {31'h0, stop_entry_o});
    apb(1'b1, sowr_pkg::ADDR_MASK, 32'h7);
    chk("irq", 32'h1, {31'h0, irq_o});
    apb(1'b1, sowr_pkg::ADDR_STATUS, 32'h4);
    chk("irq", 32'h0, {31'h0, irq_o});
    apb(1'b1, sowr_pkg::ADDR_OPTIONS, 32'h9f);
    apb(1'b1, sowr_pkg::ADDR_OPTIONS, 32'h00);
    rdchk("options", sowr_pkg::ADDR_OPTIONS, 32'h9f);
    chk("opts_o", 32'h9f, {24'h0, options_o});
    chk("period", 32'h00000010, {27'h0, period_o});
    chk("range", 32'h1, {31'h0, range_o});
    rdchk("status", sowr_pkg::ADDR_STATUS, 32'h101);
    apb(1'b1, sowr_pkg::ADDR_STATUS, 32'h1);
    // early service: threshold is 3/4 of 2^16
    @(posedge clock_i) wd_count <= 20'hbfff;
    pulse(1);
    chk("win_rst", 32'h1, {31'h0, win_rst_o});
    @(posedge clock_i) wd_count <= 20'hc000;
    pulse(1);
    chk("win_rst", 32'h0, {31'h0, win_rst_o});
    rdchk("status", sowr_pkg::ADDR_STATUS, 32'h102);
    pulse(0);
    chk("stop", 32'h1, {31'h0, stop_entry_o});
    // no wake event in the first cycles after a stop with fast wakeup set
    repeat (9) @(posedge clock_i);
    pulse(2);
    chk("skip_isr", 32'h1, {31'h0, skip_isr_o});
    apb(1'b0, 16'h1810, 32'h0);
    chk("slverr", 32'h1, {31'h0, er});
    chk("rd_unmapped", 32'h0, rd);
    // every timeout code, lock cleared by each reset
    for (int i = 0; i < 4; i++) begin
      do_reset(2);
      chk("opts_rst", 32'h000000c0, {24'h0, options_o});
      apb(1'b1, sowr_pkg::ADDR_OPTIONS, {24'h0, tbl_val[i]});
      chk("opts_o", {24'h0, tbl_val[i]}, {24'h0, options_o});
      chk("enable", {31'h0, (i != 0)}, {31'h0, wd_en_o});
      chk("period", {27'h0, tbl_per[i]}, {27'h0, period_o});
    end
    pulse(2);
    chk("skip_isr", 32'h0, {31'h0, skip_isr_o});
    @(posedge clock_i) wd_count <= 20'h0;
    pulse(1);
    chk("win_rst", 32'h0, {31'h0, win_rst_o});
    results();
  end

  // watchdog against a hung handshake
  initial begin
    repeat (5000) @(posedge clock_i);
    err_total++;
    results();
  end
endmodule
